// ==== core/lsg_cfg_decoder.v ====
// General configuration group decoder for a stepper node, Wishbone slave
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "lsg_cfg_map.vh"

// Behaviour
// - Group 0 addressed frame loads new node id
// - Later frames must match the new id
// - Byte 1 gives phase, ramp, step options
// - Byte 2 upper nibble sets stopped limit
// - Byte 2 lower nibble sets running limit
// - Byte 3 is reserved and ignored
// - Non-sleep requests need matching node id
// - Service byte selects upload, download, store
// - Group selector picks section; store persists
module lsg_cfg_decoder (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    output reg  [7:0]  node_id_o,
    output reg         positive_dir_phase_order_o,
    output reg         ramp_enable_bit_o,
    output reg         full_step_select_o,
    output reg  [2:0]  stop_limit_o,
    output reg  [2:0]  run_limit_o,
    output reg         store_req_o
);

    // Register map, one 32-bit word per offset:
    //   FRAME_LO  lanes 0..3 hold data bytes 0..3
    //   FRAME_HI  lane 0 service, lane 1 target node, lane 2 group
    //   CTRL      bit 0 written as 1 executes the held frame
    //   NODE_ID   current node id, read only
    //   OPTION    option byte last loaded, read only
    //   LIMITS    packed stopped and running codes, read only
    //   STATUS    bit 0 accepted, bit 1 rejected, bit 2 unstored change
    // Accepted and rejected clear on a written 1; the unstored flag
    // clears only when a store frame is accepted.
    // Unmapped offsets read zero and drop writes but still answer,
    // so a stray access never hangs the bus.

    // Frame holding registers, written by software before a go strobe
    reg [7:0]  cfg_data_byte0_q;
    reg [7:0]  cfg_data_byte1_q;
    reg [7:0]  cfg_data_byte2_q;
    reg [7:0]  cfg_data_byte3_q;
    reg [7:0]  target_node_field_q;
    reg [7:0]  param_group_select_q;
    reg [7:0]  service_code_field_q;
    // Live configuration, loaded only by an accepted general download
    reg [7:0]  app_option_byte_q;
    reg [7:0]  coil_current_limits_q;
    // One-cycle execute pulse from the control word
    reg        go_q;
    // Status flags, visible in the status word
    reg        accepted_q;
    reg        rejected_q;
    reg        dirty_q;

    // Map a nibble code to the limit encoding; shared by both nibbles
    // Codes 8..F fall back to no limitation, not off, so a corrupt
    // byte cannot drop the holding current of a parked motor.
    function [2:0] lim_decode;
        input [3:0] code;
        input       stopped;
        begin
            case (code)
                4'h0:    lim_decode = stopped ? `LSG_LIM_OFF : `LSG_LIM_NONE;
                4'h1:    lim_decode = `LSG_LIM_NONE;
                4'h2:    lim_decode = `LSG_LIM_NONE;
                4'h3:    lim_decode = `LSG_LIM_60MA;
                4'h4:    lim_decode = `LSG_LIM_250MA;
                4'h5:    lim_decode = `LSG_LIM_350MA;
                4'h6:    lim_decode = `LSG_LIM_500MA;
                4'h7:    lim_decode = `LSG_LIM_700MA;
                default: lim_decode = `LSG_LIM_NONE;   // Codes 8..F undefined, no limit
            endcase
        end
    endfunction

    // Byte-lane merge for a written word
    // Lanes with a clear byte enable keep their old value
    function [7:0] lane;
        input [7:0]  old;
        input [31:0] wd;
        input [3:0]  sel;
        input [1:0]  idx;
        begin
            lane = sel[idx] ? wd[8*idx +: 8] : old;
        end
    endfunction

    // Request decode: ack masks the held strobe so it is taken once
    wire       bus_req   = cyc_i & stb_i & ~ack_o;
    wire       wr_req    = bus_req & we_i;
    // Node match is against the live id, so a changed id governs later frames
    wire       id_match  = (target_node_field_q == node_id_o);
    wire       is_sleep  = (service_code_field_q == `LSG_SVC_SLEEP);
    wire       for_us    = is_sleep | id_match;
    wire       general   = (param_group_select_q == `LSG_GRP_GENERAL);
    wire       do_load   = go_q & for_us & general &
                           (service_code_field_q == `LSG_SVC_DOWNLOAD);
    // Store needs a real match; a sleep broadcast never persists
    wire       do_store  = go_q & id_match & ~is_sleep &
                           (service_code_field_q == `LSG_SVC_STORE);
    wire       do_accept = go_q & for_us;

    // Execute timing: control write taken at edge 0, go stands in
    // cycle 1, held bytes and node id land at edge 1, option and limit outputs follow at edge 2.
    // The next bus request is taken at edge 2 at the earliest, so a
    // frame word rewrite can never overtake a frame in flight.
    // Register writes and frame execution
    always @(posedge clk_i) begin
        if (rst_i) begin
            // Frame words clear; live settings return to power-on values
            cfg_data_byte0_q      <= 8'h00;
            cfg_data_byte1_q      <= 8'h00;
            cfg_data_byte2_q      <= 8'h00;
            cfg_data_byte3_q      <= 8'h00;
            target_node_field_q   <= 8'h00;
            param_group_select_q  <= 8'h00;
            service_code_field_q  <= 8'h00;
            go_q                  <= 1'b0;
            node_id_o             <= `LSG_RST_NODE_ID;
            app_option_byte_q     <= `LSG_RST_OPTION;
            coil_current_limits_q <= `LSG_RST_LIMITS;
            accepted_q            <= 1'b0;
            rejected_q            <= 1'b0;
            dirty_q               <= 1'b0;
            store_req_o           <= 1'b0;
        end else begin
            // Execute pulse and store request, each one cycle wide
            go_q        <= wr_req & (adr_i == `LSG_OFF_CTRL) & sel_i[0] &
                           dat_i[`LSG_CTRL_GO_BIT];
            store_req_o <= do_store;
            // Data word: each lane written only where enabled
            if (wr_req && adr_i == `LSG_OFF_FRAME_LO) begin
                cfg_data_byte0_q <= lane(cfg_data_byte0_q, dat_i, sel_i, 2'd0);
                cfg_data_byte1_q <= lane(cfg_data_byte1_q, dat_i, sel_i, 2'd1);
                cfg_data_byte2_q <= lane(cfg_data_byte2_q, dat_i, sel_i, 2'd2);
                cfg_data_byte3_q <= lane(cfg_data_byte3_q, dat_i, sel_i, 2'd3);
            end
            // Header word: service, target node and group
            if (wr_req && adr_i == `LSG_OFF_FRAME_HI) begin
                service_code_field_q <= lane(service_code_field_q, dat_i, sel_i, 2'd0);
                target_node_field_q  <= lane(target_node_field_q, dat_i, sel_i, 2'd1);
                param_group_select_q <= lane(param_group_select_q, dat_i, sel_i, 2'd2);
            end
            // Status: hardware set wins over the software clear
            if (wr_req && adr_i == `LSG_OFF_STATUS && sel_i[0]) begin
                if (dat_i[0]) accepted_q <= 1'b0;
                if (dat_i[1]) rejected_q <= 1'b0;
            end
            if (do_accept) accepted_q <= 1'b1;
            if (go_q && !for_us) rejected_q <= 1'b1;
            if (do_store) dirty_q <= 1'b0;
            // Only sleep needs no match; sleep never loads parameters
            if (do_load) begin
                node_id_o             <= cfg_data_byte0_q;
                app_option_byte_q     <= cfg_data_byte1_q;
                // Limits stay packed; the nibbles decode at the output stage
                coil_current_limits_q <= cfg_data_byte2_q;
                dirty_q               <= 1'b1;
                // Byte 3 deliberately not consumed
            end
        end
    end

    // Option and limit outputs registered from the stored bytes
    // One edge behind the stored bytes so every output is a flip-flop;
    // a new limit therefore applies one cycle after the id.
    always @(posedge clk_i) begin
        if (rst_i) begin
            // Limits reset to no limitation, matching the limits byte
            positive_dir_phase_order_o <= 1'b0;
            ramp_enable_bit_o          <= 1'b0;
            full_step_select_o         <= 1'b0;
            stop_limit_o               <= `LSG_LIM_NONE;
            run_limit_o                <= `LSG_LIM_NONE;
        end else begin
            positive_dir_phase_order_o <= app_option_byte_q[`LSG_OPT_PHASE_BIT];
            ramp_enable_bit_o          <= app_option_byte_q[`LSG_OPT_RAMP_BIT];
            full_step_select_o         <= app_option_byte_q[`LSG_OPT_FULL_BIT];
            stop_limit_o <= lim_decode(coil_current_limits_q[7:4], 1'b1);
            run_limit_o  <= lim_decode(coil_current_limits_q[3:0], 1'b0);
        end
    end

    // Wishbone answer: ack one cycle after strobe, unmapped reads zero
    // A write lands at the taking edge, the same edge that raises its ack;
    // a read returns the value standing at that same edge.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            // Read data stands only with the ack, zero otherwise
            ack_o <= bus_req;
            dat_o <= 32'h0000_0000;
            if (bus_req && !we_i) begin
                case (adr_i)
                    `LSG_OFF_FRAME_LO: dat_o <= {cfg_data_byte3_q, cfg_data_byte2_q,
                                                 cfg_data_byte1_q, cfg_data_byte0_q};
                    `LSG_OFF_FRAME_HI: dat_o <= {8'h00, param_group_select_q,
                                                 target_node_field_q, service_code_field_q};
                    `LSG_OFF_NODE_ID:  dat_o <= {24'h00_0000, node_id_o};
                    `LSG_OFF_OPTION:   dat_o <= {24'h00_0000, app_option_byte_q};
                    `LSG_OFF_LIMITS:   dat_o <= {24'h00_0000, coil_current_limits_q};
                    `LSG_OFF_STATUS:   dat_o <= {29'h0000_0000, dirty_q, rejected_q,
                                                 accepted_q};
                    default:           dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // lsg_cfg_decoder

// ==== core/lsg_cfg_map.vh ====
// Constants for the general configuration decoder: offsets, fields, resets, codes
`ifndef LSG_CFG_MAP_VH
`define LSG_CFG_MAP_VH

// Register word offsets (byte addresses)
`define LSG_OFF_FRAME_LO   8'h00
`define LSG_OFF_FRAME_HI   8'h04
`define LSG_OFF_CTRL       8'h08
`define LSG_OFF_NODE_ID    8'h0C
`define LSG_OFF_OPTION     8'h10
`define LSG_OFF_LIMITS     8'h14
`define LSG_OFF_STATUS     8'h18

// Service codes
`define LSG_SVC_SLEEP      8'h00
`define LSG_SVC_UPLOAD     8'h80
`define LSG_SVC_DOWNLOAD   8'h81
`define LSG_SVC_STORE      8'h82

// Parameter group for general configuration
`define LSG_GRP_GENERAL    8'h00

// Option byte bits
`define LSG_OPT_PHASE_BIT  3
`define LSG_OPT_RAMP_BIT   6
`define LSG_OPT_FULL_BIT   7

// Current limit codes on output
`define LSG_LIM_OFF        3'h0
`define LSG_LIM_NONE       3'h1
`define LSG_LIM_60MA       3'h2
`define LSG_LIM_250MA      3'h3
`define LSG_LIM_350MA      3'h4
`define LSG_LIM_500MA      3'h5
`define LSG_LIM_700MA      3'h6

// Reset values
`define LSG_RST_NODE_ID    8'h01
`define LSG_RST_OPTION     8'h00
`define LSG_RST_LIMITS     8'h11

// Control register bits
`define LSG_CTRL_GO_BIT    0

`endif

// ==== test/lsg_lin_master.sv ====
// Behavioural LIN master packing config requests into register words
`timescale 1ns/1ps
module lsg_lin_master (
    input  wire logic [23:0] head_i,
    input  wire logic [31:0] data_i,
    output logic      [31:0] lo_o,
    output logic      [31:0] hi_o
);
    // Byte 3 goes out as the scenario sets it; the device must not care
    assign lo_o = data_i;
    // Service, target node and group; node is sent as given, even a stale id
    assign hi_o = {8'h00, head_i};
endmodule // lsg_lin_master

// ==== test/lsg_cfg_monitor.sv ====
// Port assertions for the configuration decoder
`timescale 1ns/1ps
`include "lsg_cfg_map.vh"
module lsg_cfg_monitor (
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [7:0]  adr_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    input wire [7:0]  node_id_o,
    input wire [2:0]  stop_limit_o,
    input wire [2:0]  run_limit_o,
    input wire        store_req_o
);
    reg go_q;
    reg go2_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Execute write one and two cycles back; outputs may only move then
    always @(posedge clk_i) begin
        go_q  <= !rst_i && ack_o && we_i && adr_i == `LSG_OFF_CTRL && dat_i[0];
        go2_q <= !rst_i && go_q;
    end
    sequence s_take; cyc_i && stb_i && !ack_o; endsequence
    sequence s_hole; s_take ##0 (!we_i && adr_i > `LSG_OFF_STATUS); endsequence
    a_ack_next: assert property (s_take |=> ack_o) else $error("no ack");
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("long ack");
    a_dat_idle: assert property (!ack_o |-> dat_o == 0) else $error("stray data");
    a_hole_zero: assert property (s_hole |=> dat_o == 0) else $error("hole not zero");
    a_node_cause: assert property ($changed(node_id_o) |-> go_q || $past(rst_i))
        else $error("node id moved");
    a_limit_cause: assert property ($changed({stop_limit_o, run_limit_o}) |-> go2_q || $past(rst_i))
        else $error("limits moved");
    a_limit_code: assert property (stop_limit_o <= 3'h6 && run_limit_o <= 3'h6)
        else $error("bad limit code");
    a_store_pulse: assert property (store_req_o |-> go_q ##1 !store_req_o)
        else $error("bad store pulse");
endmodule // lsg_cfg_monitor
bind lsg_cfg_decoder lsg_cfg_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .node_id_o(node_id_o), .stop_limit_o(stop_limit_o), .run_limit_o(run_limit_o),
    .store_req_o(store_req_o));

// ==== test/lsg_cfg_decoder_bench.sv ====
// Self-checking bench for the configuration decoder
`timescale 1ns/1ps
`include "lsg_cfg_map.vh"
module lsg_cfg_decoder_bench;
    localparam logic [7:0] DL = `LSG_SVC_DOWNLOAD;
    localparam logic [7:0] GEN = `LSG_GRP_GENERAL;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [7:0]  adr_i = 0, opt, lb, node_id_o;
    logic [3:0]  sel_i = 0;
    logic [31:0] dat_i = 0, dat_o, rd, lo, hi, fr_data = 0;
    logic [23:0] fr_head = 0;
    logic [2:0]  stop_limit_o, run_limit_o;
    logic        ack_o, positive_dir_phase_order_o, ramp_enable_bit_o;
    logic        full_step_select_o, store_req_o;
    int          n_errors = 0, comparisons = 0, n_store = 0;
    lsg_cfg_decoder DUT (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .node_id_o(node_id_o), .positive_dir_phase_order_o(positive_dir_phase_order_o),
        .ramp_enable_bit_o(ramp_enable_bit_o), .full_step_select_o(full_step_select_o),
        .stop_limit_o(stop_limit_o), .run_limit_o(run_limit_o), .store_req_o(store_req_o));
    lsg_lin_master PM (.head_i(fr_head), .data_i(fr_data), .lo_o(lo), .hi_o(hi));
    initial forever #5 clk_i = ~clk_i;
    // Store pulses stand one cycle, so count them at every edge
    always @(posedge clk_i) if (store_req_o === 1'b1) n_store <= n_store + 1;
    task automatic chk(input [31:0] seen, input [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Classic cycle; no fixed latency assumed, the watchdog bounds the wait
    task automatic wb(input [7:0] a, input w, input [31:0] d);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hF};
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rd = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic frame(input [23:0] h, input [31:0] d);
        fr_head = h;
        fr_data = d;
        @(posedge clk_i);
        wb(`LSG_OFF_FRAME_LO, 1, lo);
        wb(`LSG_OFF_FRAME_HI, 1, hi);
        wb(`LSG_OFF_CTRL, 1, 32'h1);
        repeat (2) @(posedge clk_i);
    endtask
    function automatic [2:0] lim(input [3:0] c, input stopped);
        lim = (c == 0 && stopped) ? 3'h0 : (c > 2 && c < 8) ? c[2:0] - 3'h1 : 3'h1;
    endfunction
    task automatic expect_state(input [7:0] n, input [7:0] o, input [7:0] l);
        chk(node_id_o, n);
        chk({full_step_select_o, ramp_enable_bit_o, positive_dir_phase_order_o}, {o[7], o[6], o[3]});
        chk({stop_limit_o, run_limit_o}, {lim(l[7:4], 1), lim(l[3:0], 0)});
    endtask
    task automatic end_of_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        expect_state(8'h01, 8'h00, 8'h11);
        // Every nibble code in both limits, with junk in the reserved byte
        for (int i = 0; i < 16; i++) begin
            opt = 8'(i * 73);
            lb = {i[3:0], ~i[3:0]};
            frame({GEN, 8'h01, DL}, {8'(i) ^ 8'hA5, lb, opt, 8'h01});
            expect_state(8'h01, opt, lb);
        end
        frame({GEN, 8'h05, DL}, 32'h0000_3302);
        expect_state(8'h01, opt, lb);
        wb(`LSG_OFF_STATUS, 0, 0);
        chk(rd, 32'h0000_0007);
        // Clear both flags, then a sleep broadcast to a foreign id is still taken
        wb(`LSG_OFF_STATUS, 1, 32'h0000_0003);
        frame({GEN, 8'h05, `LSG_SVC_SLEEP}, 32'h0000_3302);
        expect_state(8'h01, opt, lb);
        wb(`LSG_OFF_STATUS, 0, 0);
        chk(rd, 32'h0000_0005);
        frame({8'h01, 8'h01, DL}, 32'h0000_3302);
        expect_state(8'h01, opt, lb);
        frame({GEN, 8'h01, `LSG_SVC_UPLOAD}, 32'h0000_3302);
        expect_state(8'h01, opt, lb);
        frame({GEN, 8'h01, DL}, 32'h0033_80FF);
        expect_state(8'hFF, 8'h80, 8'h33);
        // Old id must no longer reach the node
        frame({GEN, 8'h01, DL}, 32'h0077_0001);
        expect_state(8'hFF, 8'h80, 8'h33);
        frame({GEN, 8'hFF, `LSG_SVC_STORE}, 32'h0);
        chk(n_store, 1);
        wb(`LSG_OFF_STATUS, 0, 0);
        chk(rd, 32'h0000_0003);
        wb(`LSG_OFF_NODE_ID, 0, 0);
        chk(rd, 32'h0000_00FF);
        wb(8'hFC, 0, 0);
        end_of_test;
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        n_errors++;
        end_of_test;
    end
endmodule // lsg_cfg_decoder_bench
